// [rtl/mrr_pkg.sv]
// Package: addresses, reset values and carrier types of the metering result bank
package mrr_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned VALUE_W = 24;

  // ----------------------------------------------------------------
  // Extended SFR byte addresses
  // ----------------------------------------------------------------
  localparam logic [11:0] CURRENT1_RMS_LOW_ADDR = 12'h18c;
  localparam logic [11:0] CURRENT1_RMS_MID_ADDR = 12'h18d;
  localparam logic [11:0] CURRENT1_RMS_HIGH_ADDR = 12'h18e;
  localparam logic [11:0] CURRENT2_RMS_LOW_ADDR = 12'h18f;
  localparam logic [11:0] CURRENT2_RMS_MID_ADDR = 12'h190;
  localparam logic [11:0] CURRENT2_RMS_HIGH_ADDR = 12'h191;
  localparam logic [11:0] ACTIVE_ENERGY_LOW_ADDR = 12'h192;
  localparam logic [11:0] ACTIVE_ENERGY_MID_ADDR = 12'h193;
  localparam logic [11:0] ACTIVE_ENERGY_HIGH_ADDR = 12'h194;
  localparam logic [11:0] READ_CLEAR_LOW_ADDR = 12'h196;
  localparam logic [11:0] READ_CLEAR_MID_ADDR = 12'h197;
  localparam logic [11:0] READ_CLEAR_HIGH_ADDR = 12'h198;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [23:0] VALUE_RESET = 24'h000000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    MRR_VIEW_NONE = 5'h01,
    MRR_VIEW_CUR1 = 5'h02,
    MRR_VIEW_CUR2 = 5'h04,
    MRR_VIEW_ACT = 5'h08,
    MRR_VIEW_ACT_CLR = 5'h10
  } mrr_view_type;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [11:0] addr;
    logic [7:0] wdata;
  } mrr_esfr_req_type;

  typedef struct packed {
    logic cur1_valid;
    logic [23:0] cur1;
    logic cur2_valid;
    logic [23:0] cur2;
    logic pwr_valid;
    logic [23:0] pwr_inc;
  } mrr_meas_type;

endpackage

// [rtl/mrr_accum.sv]
// Module: 24-bit active power accumulator with clear
`timescale 1ns/1ps

module mrr_accum (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Accumulation input
  input wire logic add_valid,
  input wire logic [23:0] add_value,
  // Clear request from the read-clear view
  input wire logic clear,
  // Accumulated value
  output logic [23:0] value,
  output logic wrap
);

  logic [23:0] value_reg;
  logic [23:0] value_next;
  logic wrap_reg;
  logic wrap_next;
  logic [24:0] sum;

  // ----------------------------------------------------------------
  // Next value
  // ----------------------------------------------------------------
  always_comb
  begin
    sum = 25'h0;
    value_next = value_reg;
    wrap_next = 1'b0;
    if (clear)
    begin
      // Increment arriving with the clear is kept
      if (add_valid)
      begin
        value_next = add_value;
      end
      else
      begin
        value_next = mrr_pkg::VALUE_RESET;
      end
    end
    else if (add_valid)
    begin
      sum = {1'b0, value_reg} + {1'b0, add_value};
      value_next = sum[23:0];
      wrap_next = sum[24];
    end
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      value_reg <= mrr_pkg::VALUE_RESET; // [R07]
    end
    else
    begin
      value_reg <= value_next;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wrap_reg <= 1'b0;
    end
    else
    begin
      wrap_reg <= wrap_next;
    end
  end

  assign value = value_reg;
  assign wrap = wrap_reg;

endmodule // mrr_accum

// [rtl/mrr_readout.sv]
// Module: read-only metering result bank on the extended SFR port
//
// Function
// [R01] Keep latest 24-bit RMS per current channel
// [R02] Current RMS bytes at 18C/18F, low first
// [R03] Reset clears both current RMS values
// [R04] Reached only through extended SFR port
// [R05] Active energy bytes from 192, low first
// [R06] Reading active energy view never clears it
// [R07] Reset clears the active energy accumulator
// [R08] View at 196 clears accumulator after read
// [R09] Writes to result bytes are ignored
`timescale 1ns/1ps

module mrr_readout (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Extended SFR port
  input wire mrr_pkg::mrr_esfr_req_type esfr_req,
  output logic [7:0] esfr_rdata,
  output logic esfr_rvalid,
  // Measurement results from the calculation unit
  input wire mrr_pkg::mrr_meas_type meas,
  // Result values for the rest of the metering unit
  output logic [23:0] current1_rms_value,
  output logic [23:0] current2_rms_value,
  output logic [23:0] active_energy_value,
  output logic active_energy_wrap
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // True when an address lies in the three bytes of a view
  function automatic logic in_view(input logic [11:0] addr, input logic [11:0] base);
    logic hit;
    hit = 1'b0;
    if (addr >= base && addr <= base + 12'h002)
    begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  // Which three-byte view an address falls in
  function automatic mrr_pkg::mrr_view_type view_of(input logic [11:0] addr);
    mrr_pkg::mrr_view_type v;
    v = mrr_pkg::MRR_VIEW_NONE;
    if (in_view(addr, mrr_pkg::CURRENT1_RMS_LOW_ADDR))
    begin
      v = mrr_pkg::MRR_VIEW_CUR1;
    end
    else if (in_view(addr, mrr_pkg::CURRENT2_RMS_LOW_ADDR))
    begin
      v = mrr_pkg::MRR_VIEW_CUR2;
    end
    else if (in_view(addr, mrr_pkg::ACTIVE_ENERGY_LOW_ADDR))
    begin
      v = mrr_pkg::MRR_VIEW_ACT;
    end
    else if (in_view(addr, mrr_pkg::READ_CLEAR_LOW_ADDR))
    begin
      v = mrr_pkg::MRR_VIEW_ACT_CLR;
    end
    return v;
  endfunction

  // Byte of a 24-bit value at an offset from the view base, low first
  function automatic logic [7:0] byte_of(input logic [23:0] value, input logic [11:0] offset);
    logic [7:0] b;
    b = mrr_pkg::BYTE_RESET;
    case (offset)
      12'h000: b = value[7:0];
      12'h001: b = value[15:8];
      12'h002: b = value[23:16];
      default: b = mrr_pkg::BYTE_RESET;
    endcase
    return b;
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [23:0] current1_rms_reg;
  logic [23:0] current2_rms_reg;
  logic [23:0] clear_snap_reg;
  logic [23:0] clear_snap_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rvalid_reg;
  logic read_take;
  logic accum_clear;
  logic [23:0] accum_value;
  logic accum_wrap;
  mrr_pkg::mrr_view_type req_view;
  logic [11:0] req_offset;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // A write in the same cycle wins, so such a read is not taken
  assign read_take = esfr_req.rd && !esfr_req.wr; // [R09]

  always_comb
  begin
    req_view = view_of(esfr_req.addr); // [R04]
    case (req_view)
      mrr_pkg::MRR_VIEW_CUR1: req_offset = esfr_req.addr - mrr_pkg::CURRENT1_RMS_LOW_ADDR;
      mrr_pkg::MRR_VIEW_CUR2: req_offset = esfr_req.addr - mrr_pkg::CURRENT2_RMS_LOW_ADDR;
      mrr_pkg::MRR_VIEW_ACT: req_offset = esfr_req.addr - mrr_pkg::ACTIVE_ENERGY_LOW_ADDR;
      mrr_pkg::MRR_VIEW_ACT_CLR: req_offset = esfr_req.addr - mrr_pkg::READ_CLEAR_LOW_ADDR;
      default: req_offset = 12'h000;
    endcase
  end

  // ----------------------------------------------------------------
  // Current channel RMS holding registers
  // ----------------------------------------------------------------
  // Only the calculation unit updates them; host writes never reach here
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      current1_rms_reg <= mrr_pkg::VALUE_RESET; // [R03]
    end
    else if (meas.cur1_valid)
    begin
      current1_rms_reg <= meas.cur1; // [R01]
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      current2_rms_reg <= mrr_pkg::VALUE_RESET; // [R03]
    end
    else if (meas.cur2_valid)
    begin
      current2_rms_reg <= meas.cur2; // [R01]
    end
  end

  // ----------------------------------------------------------------
  // Active power accumulator
  // ----------------------------------------------------------------
  // Only a low-byte read of the read-clear view clears; writes and reads
  // of the plain view leave it alone
  assign accum_clear = read_take
    && req_view == mrr_pkg::MRR_VIEW_ACT_CLR && req_offset == 12'h000; // [R08] [R06] [R09]

  mrr_accum u_accum (
    .clk(clk),
    .srst(srst),
    .add_valid(meas.pwr_valid),
    .add_value(meas.pwr_inc),
    .clear(accum_clear),
    .value(accum_value),
    .wrap(accum_wrap)
  );

  // ----------------------------------------------------------------
  // Read-clear snapshot
  // ----------------------------------------------------------------
  // Holds the value taken at the clearing low-byte read, so that the
  // mid and high bytes belong to the same reading
  always_comb
  begin
    clear_snap_next = clear_snap_reg;
    if (accum_clear)
    begin
      clear_snap_next = accum_value; // [R08]
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      clear_snap_reg <= mrr_pkg::VALUE_RESET;
    end
    else
    begin
      clear_snap_reg <= clear_snap_next;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb
  begin
    rdata_next = mrr_pkg::UNMAPPED_DATA;
    case (req_view)
      mrr_pkg::MRR_VIEW_CUR1: rdata_next = byte_of(current1_rms_reg, req_offset); // [R02]
      mrr_pkg::MRR_VIEW_CUR2: rdata_next = byte_of(current2_rms_reg, req_offset); // [R02]
      mrr_pkg::MRR_VIEW_ACT: rdata_next = byte_of(accum_value, req_offset); // [R05] [R06]
      mrr_pkg::MRR_VIEW_ACT_CLR:
      begin
        if (req_offset == 12'h000)
        begin
          rdata_next = byte_of(accum_value, req_offset); // [R08]
        end
        else
        begin
          rdata_next = byte_of(clear_snap_reg, req_offset); // [R08]
        end
      end
      mrr_pkg::MRR_VIEW_NONE: rdata_next = mrr_pkg::UNMAPPED_DATA;
      default: rdata_next = mrr_pkg::UNMAPPED_DATA;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rdata_reg <= mrr_pkg::BYTE_RESET;
    end
    else if (read_take)
    begin
      rdata_reg <= rdata_next;
    end
  end

  // Write strobes are accepted and dropped
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rvalid_reg <= 1'b0;
    end
    else
    begin
      rvalid_reg <= read_take; // [R09]
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign esfr_rdata = rdata_reg;
  assign esfr_rvalid = rvalid_reg;
  assign current1_rms_value = current1_rms_reg;
  assign current2_rms_value = current2_rms_reg;
  assign active_energy_value = accum_value;
  assign active_energy_wrap = accum_wrap;

endmodule // mrr_readout

// [testbench/mrr_readout_chk.sv]
// Checker: port behaviour of the metering result bank
`timescale 1ns/1ps

module mrr_readout_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Watched ports
  input wire mrr_pkg::mrr_esfr_req_type esfr_req,
  input wire logic [7:0] esfr_rdata,
  input wire logic esfr_rvalid,
  input wire mrr_pkg::mrr_meas_type meas,
  input wire logic [23:0] current1_rms_value,
  input wire logic [23:0] current2_rms_value,
  input wire logic [23:0] active_energy_value,
  input wire logic active_energy_wrap
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  sequence s_rd(a);
    esfr_req.rd && !esfr_req.wr && esfr_req.addr == a;
  endsequence

  property p_take; esfr_req.rd && !esfr_req.wr |=> esfr_rvalid; endproperty
  a_take: assert property (p_take) else $error("read not answered");
  property p_wr; esfr_req.wr |=> !esfr_rvalid && $stable(esfr_rdata); endproperty
  a_wr: assert property (p_wr) else $error("write disturbed read port");
  property p_rst;
    disable iff (1'b0) srst |=> !esfr_rvalid && current1_rms_value == 24'h0 &&
      current2_rms_value == 24'h0 && active_energy_value == 24'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset left a value");
  property p_c1; meas.cur1_valid |=> current1_rms_value == $past(meas.cur1); endproperty
  a_c1: assert property (p_c1) else $error("channel one not loaded");
  property p_c2; meas.cur2_valid |=> current2_rms_value == $past(meas.cur2); endproperty
  a_c2: assert property (p_c2) else $error("channel two not loaded");
  property p_hold; !meas.cur1_valid |=> $stable(current1_rms_value); endproperty
  a_hold: assert property (p_hold) else $error("channel one changed");
  property p_rd1; s_rd(12'h18c) |=> esfr_rdata == $past(current1_rms_value[7:0]); endproperty
  a_rd1: assert property (p_rd1) else $error("channel one low byte");
  property p_rd2; s_rd(12'h191) |=> esfr_rdata == $past(current2_rms_value[23:16]); endproperty
  a_rd2: assert property (p_rd2) else $error("channel two high byte");
  property p_rd3; s_rd(12'h193) |=> esfr_rdata == $past(active_energy_value[15:8]); endproperty
  a_rd3: assert property (p_rd3) else $error("energy mid byte");
  property p_keep;
    s_rd(12'h192) ##0 !meas.pwr_valid |=> $stable(active_energy_value);
  endproperty
  a_keep: assert property (p_keep) else $error("energy view cleared");
  property p_clr; s_rd(12'h196) ##0 !meas.pwr_valid |=> active_energy_value == 24'h0; endproperty
  a_clr: assert property (p_clr) else $error("energy not cleared");
  // Carry pulse follows every add that passes the top of the 24-bit range
  property p_wrap;
    meas.pwr_valid && !(esfr_req.rd && !esfr_req.wr && esfr_req.addr == 12'h196)
      |=> active_energy_wrap == (active_energy_value < $past(active_energy_value));
  endproperty
  a_wrap: assert property (p_wrap) else $error("energy carry pulse wrong");
endmodule // mrr_readout_chk

bind mrr_readout mrr_readout_chk u_chk (
  .clk(clk),
  .srst(srst),
  .esfr_req(esfr_req),
  .esfr_rdata(esfr_rdata),
  .esfr_rvalid(esfr_rvalid),
  .meas(meas),
  .current1_rms_value(current1_rms_value),
  .current2_rms_value(current2_rms_value),
  .active_energy_value(active_energy_value),
  .active_energy_wrap(active_energy_wrap)
);

// [testbench/mrr_host_model.sv]
// Partner: host CPU side of the extended SFR port
`timescale 1ns/1ps

module mrr_host_model (
  // Clock
  input wire logic clk,
  // Extended SFR port
  output mrr_pkg::mrr_esfr_req_type esfr_req,
  input wire logic [7:0] esfr_rdata,
  input wire logic esfr_rvalid
);
  initial esfr_req = '0;

  // Byte read; released lines carry inverted junk
  task automatic rd(input logic [11:0] a, output logic [7:0] d, output bit ok);
    ok = 1'b0;
    d = 8'h00;
    @(posedge clk);
    esfr_req <= {1'b1, 1'b0, a, 8'h5a};
    @(posedge clk);
    esfr_req <= {1'b0, 1'b0, ~a, 8'ha5};
    repeat (4)
    begin
      @(negedge clk);
      if (esfr_rvalid === 1'b1 && !ok)
      begin
        d = esfr_rdata;
        ok = 1'b1;
      end
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    esfr_req <= {1'b0, 1'b1, a, d};
    @(posedge clk);
    esfr_req <= {1'b0, 1'b0, ~a, ~d};
  endtask
endmodule // mrr_host_model

// [testbench/mrr_readout_tb_top.sv]
// Testbench: self-checking run of the metering result bank
`timescale 1ns/1ps

module mrr_readout_tb_top;
  logic clk = 1'b0;
  logic srst = 1'b1;
  mrr_pkg::mrr_esfr_req_type esfr_req;
  mrr_pkg::mrr_meas_type meas = '0;
  logic [7:0] esfr_rdata;
  logic esfr_rvalid;
  logic [23:0] cur1, cur2, act;
  logic wrap;
  int errors = 0;
  int comparisons = 0;

  always #10 clk = ~clk;

  mrr_host_model host (
    .clk(clk),
    .esfr_req(esfr_req),
    .esfr_rdata(esfr_rdata),
    .esfr_rvalid(esfr_rvalid)
  );

  mrr_readout DUT (
    .clk(clk),
    .srst(srst),
    .esfr_req(esfr_req),
    .esfr_rdata(esfr_rdata),
    .esfr_rvalid(esfr_rvalid),
    .meas(meas),
    .current1_rms_value(cur1),
    .current2_rms_value(cur2),
    .active_energy_value(act),
    .active_energy_wrap(wrap)
  );

  task automatic wrap_up;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string n, input logic [23:0] g, input logic [23:0] e);
    comparisons++;
    if (g !== e)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic rb(input logic [11:0] a, input logic [7:0] e);
    logic [7:0] d;
    bit ok;
    host.rd(a, d, ok);
    if (!ok)
    begin
      errors++;
      $display("mismatch answer of %h expected 1 seen 0", a);
      wrap_up();
    end
    else
      chk($sformatf("byte %h", a), {16'h0, d}, {16'h0, e});
  endtask

  // Reads all nine result bytes against one 72-bit image
  task automatic sweep(input logic [71:0] v);
    for (int i = 0; i < 9; i++)
      rb(12'h18c + 12'(i), v[8*i +: 8]);
  endtask

  task automatic ld(input mrr_pkg::mrr_meas_type m);
    @(posedge clk);
    meas <= m;
    @(posedge clk);
    meas <= '0;
  endtask

  task automatic rst;
    @(posedge clk);
    srst <= 1'b1;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
  endtask

  initial
  begin
    rst();
    sweep(72'h0);
    $display("test reset values done");
    ld({1'b1, 24'ha1b2c3, 1'b1, 24'hd4e5f6, 1'b1, 24'h123456});
    ld({1'b0, 24'h0, 1'b0, 24'h0, 1'b1, 24'h123456});
    chk("channel one", cur1, 24'ha1b2c3);
    chk("channel two", cur2, 24'hd4e5f6);
    sweep({24'h2468ac, 24'hd4e5f6, 24'ha1b2c3});
    sweep({24'h2468ac, 24'hd4e5f6, 24'ha1b2c3});
    $display("test layout done");
    for (int i = 0; i < 9; i++)
      host.wr(12'h18c + 12'(i), 8'hff);
    sweep({24'h2468ac, 24'hd4e5f6, 24'ha1b2c3});
    rb(12'h195, 8'h00);
    rb(12'h18b, 8'h00);
    $display("test writes done");
    rb(12'h196, 8'hac);
    rb(12'h197, 8'h68);
    rb(12'h198, 8'h24);
    rb(12'h192, 8'h00);
    chk("energy", act, 24'h0);
    $display("test read clear done");
    ld({1'b0, 24'h0, 1'b0, 24'h0, 1'b1, 24'hffffff});
    @(negedge clk);
    chk("carry pulse", {23'h0, wrap}, 24'h0);
    chk("energy", act, 24'hffffff);
    ld({1'b0, 24'h0, 1'b0, 24'h0, 1'b1, 24'h000002});
    @(negedge clk);
    chk("carry pulse", {23'h0, wrap}, 24'h1);
    chk("energy", act, 24'h000001);
    rb(12'h192, 8'h01);
    $display("test wrap done");
    rst();
    sweep(72'h0);
    $display("test second reset done");
    wrap_up();
  end
endmodule // mrr_readout_tb_top
